// ===== shared/timer_pkg.sv
// Purpose: shared constants for the reload/compare timer
// Assumes: byte wide registers on a 32-bit classic Wishbone slave
// Notes: register index times four gives the byte address
package timer_pkg;
  // register indices, byte address is index * 4
  localparam logic [7:0] IDX_CTRL = 8'hC8;
  localparam logic [7:0] IDX_MODE = 8'hC9;
  localparam logic [7:0] IDX_RC_LO = 8'hCA;
  localparam logic [7:0] IDX_RC_HI = 8'hCB;
  localparam logic [7:0] IDX_CNT_LO = 8'hCC;
  localparam logic [7:0] IDX_CNT_HI = 8'hCD;
  localparam logic [7:0] IDX_IEN = 8'hE0;
  localparam logic [7:0] IDX_STAT = 8'hE1;
  localparam logic [7:0] IDX_MASK = 8'hE2;
  // control register fields
  localparam int CTRL_FLAG = 7;
  localparam int CTRL_RUN = 2;
  localparam int CTRL_MODE = 0;
  // mode register fields
  localparam int MODE_GATE = 7;
  localparam int MODE_DIV_HI = 6;
  localparam int MODE_DIV_LO = 4;
  localparam int MODE_CAPCLR = 3;
  localparam int MODE_MCLR = 2;
  localparam int MODE_TRIG_HI = 1;
  // interrupt enable fields
  localparam int IEN_TIMER = 0;
  localparam int IEN_GLOBAL = 1;
  // sticky status bits
  localparam int ST_OVF = 0;
  localparam int ST_MATCH = 1;
  localparam int ST_RELOAD = 2;
  localparam int ST_CAPT = 3;
  localparam int ST_W = 4;
  // reset values, count top, overflow trigger code and prescaler width
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] CNT_CLEAR = 16'h0000;
  localparam logic [15:0] CNT_TOP = 16'hFFFF;
  localparam logic [1:0] TRIG_OVF = 2'h0;
  localparam int PRE_W = 9;
  // timer function, chosen by the control mode bit
  typedef enum logic {MODE_RELOAD, MODE_COMPARE} tmr_mode_t;
  // divider code to log2 of the division ratio
  function automatic logic [3:0] div_shift(input logic [2:0] code);
    case (code)
      3'h0: div_shift = 4'h0;
      3'h1: div_shift = 4'h2;
      3'h2: div_shift = 4'h4;
      3'h3: div_shift = 4'h5;
      3'h4: div_shift = 4'h6;
      3'h5: div_shift = 4'h7;
      3'h6: div_shift = 4'h8;
      default: div_shift = 4'h9;
    endcase
  endfunction : div_shift
endpackage : timer_pkg

// ===== shared/div_if.sv
// Purpose: link between the timer core and its prescaler
// Assumes: one clock domain
// Notes: tick is a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
interface div_if;
  logic run; // prescaler counts while high
  logic [2:0] code; // divider selection
  logic tick; // divided clock enable
  modport timer (output run, output code, input tick);
  modport divider (input run, input code, output tick);
endinterface : div_if
`default_nettype wire

// ===== hdl/tick_gen.sv
// Purpose: prescaler that turns the divider code into tick pulses
// Assumes: clk_i is the timer clock
// Notes: counter restarts whenever the timer is halted
`timescale 1ns/1ps
`default_nettype none
module tick_gen
  import timer_pkg::*;
#(
  parameter int W = PRE_W // prescaler width, must reach 1/512
)(
  input wire logic clk_i,
  input wire logic rst_i,
  div_if.divider dv
);
  // refuse a prescaler too short for the slowest ratio
  if (W < PRE_W) begin : g_chk
    $error("tick_gen prescaler width too small");
  end
  logic [W-1:0] pre_q; // free running prescaler
  logic [W-1:0] mask; // low bits that must all be one
  // mask grows with the selected ratio
  always_comb
  begin
    mask = W'((1 << div_shift(dv.code)) - 1);
  end
  // a tick on the last count of each period, so 1/1 ticks on every cycle while run is high
  assign dv.tick = dv.run && ((pre_q & mask) == mask);
  // prescaler holds at zero while halted for a clean first period
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !dv.run)
      pre_q <= '0;
    else
      pre_q <= pre_q + W'(1);
  end
endmodule : tick_gen
`default_nettype wire

// ===== hdl/timer_reload_compare.sv
// Purpose: 16-bit timer with auto-reload and compare modes
// Assumes: capture strobes come from logic on clk_i, one cycle each
// Notes: registers are byte wide on a classic Wishbone slave
`timescale 1ns/1ps
`default_nettype none
module timer_reload_compare
  import timer_pkg::*;
#(
  parameter int AW = 10 // byte address width, reaches index E2
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [AW-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [2:0] capture_i,
  output logic timer_irq_o,
  output logic irq_o
);
  import timer_pkg::*;
  // the word index must fit the address
  if (AW < 10) begin : g_chk
    $error("address too narrow for register map");
  end

  div_if dv ();

  // bus side state
  logic ack_q; // one wait state answer
  logic [31:0] rdat_q; // registered read data
  // timer state, all of it software visible
  logic [7:0] ctrl_q; // flag, run, mode
  logic [7:0] mode_q; // gate, divider, clears, trigger
  logic [15:0] rc_q; // reload or compare value
  logic [15:0] cnt_q; // the count
  logic [1:0] ien_q; // timer and global enables
  logic [ST_W-1:0] stat_q; // sticky events
  logic [ST_W-1:0] mask_q; // event mask
  // decoded strobes and events, combinational from bus inputs, capture strobes and state
  logic [7:0] idx; // word index of the access
  logic wr_acc; // write taking effect now
  logic rd_acc; // read completing now
  logic [7:0] rd_byte; // decoded read value
  logic step; // running and ticking
  logic ovf_ev; // count wraps this tick
  logic match_ev; // compare hit this tick
  logic cap_ev; // selected capture strobe
  logic reload_now; // copy reload into count
  logic cap_clr; // capture clears the count
  logic ar_mode; // auto-reload mode active
  logic cnt_wr; // software writes a count byte
  logic [1:0] trig; // reload trigger field

  // write strobe on one address for byte lane zero
  function automatic logic wr_to(input logic [7:0] i,
                                 input logic [7:0] r,
                                 input logic w,
                                 input logic s);
    wr_to = w && s && (i == r);
  endfunction : wr_to

  assign idx = adr_i[9:2];
  // both fire on the edge where the master sees ack
  assign wr_acc = cyc_i && stb_i && ack_q && we_i;
  assign rd_acc = cyc_i && stb_i && ack_q && !we_i;
  // both bus outputs come straight from flip-flops
  assign ack_o = ack_q;
  assign dat_o = rdat_q;
  assign trig = mode_q[MODE_TRIG_HI:0];
  assign cnt_wr = wr_to(idx, IDX_CNT_LO, wr_acc, sel_i[0]) ||
                  wr_to(idx, IDX_CNT_HI, wr_acc, sel_i[0]);

  assign ar_mode = (tmr_mode_t'(ctrl_q[CTRL_MODE]) == MODE_RELOAD);

  assign dv.run = ctrl_q[CTRL_RUN];
  assign dv.code = mode_q[MODE_DIV_HI:MODE_DIV_LO];

  // prescaler kept apart; it restarts by itself whenever run drops
  tick_gen #(.W(PRE_W)) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .dv(dv)
  );

  assign step = dv.run && dv.tick;
  assign ovf_ev = step && (cnt_q == CNT_TOP);
  assign match_ev = step && !ar_mode && (cnt_q == rc_q);
  // a zero trigger would index past the strobes, so it is masked first
  // trigger zero means overflow, else capture channel
  assign cap_ev = (trig != TRIG_OVF) && capture_i[trig - 2'h1];
  // reload only while gated on, auto-reload mode only
  assign reload_now = ar_mode && mode_q[MODE_GATE] &&
                      ((trig == TRIG_OVF) ? ovf_ev : cap_ev);
  // clear applies only in auto-reload mode
  assign cap_clr = ar_mode && cap_ev && mode_q[MODE_CAPCLR];

  // bus answer: one cycle after the request, dropped after one
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= cyc_i && stb_i && !ack_q;
  end

  // read decode, unmapped indices read as zero
  always_comb
  begin
    case (idx)
      IDX_CTRL: rd_byte = ctrl_q;
      IDX_MODE: rd_byte = mode_q;
      // two halves of the 16-bit value
      IDX_RC_LO: rd_byte = rc_q[7:0];
      IDX_RC_HI: rd_byte = rc_q[15:8];
      IDX_CNT_LO: rd_byte = cnt_q[7:0];
      IDX_CNT_HI: rd_byte = cnt_q[15:8];
      IDX_IEN: rd_byte = {6'h00, ien_q};
      IDX_STAT: rd_byte = {4'h0, stat_q};
      IDX_MASK: rd_byte = {4'h0, mask_q};
      default: rd_byte = RST_BYTE;
    endcase
  end

  // read data captured together with ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdat_q <= '0;
    else if (cyc_i && stb_i && !ack_q)
      rdat_q <= {24'h000000, rd_byte};
  end

  // control register; reserved bits stay zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_q <= RST_BYTE;
    else
    begin
      if (wr_to(idx, IDX_CTRL, wr_acc, sel_i[0]))
      begin
        // software may clear or set the flag
        ctrl_q[CTRL_FLAG] <= dat_i[CTRL_FLAG];
        ctrl_q[CTRL_RUN] <= dat_i[CTRL_RUN];
        ctrl_q[CTRL_MODE] <= dat_i[CTRL_MODE];
      end
      // hardware set beats a clearing write
      if (ovf_ev || match_ev)
        ctrl_q[CTRL_FLAG] <= 1'b1;
    end
  end

  // mode register and interrupt configuration
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_q <= RST_BYTE;
      ien_q <= '0;
      mask_q <= '0;
    end
    else
    begin
      if (wr_to(idx, IDX_MODE, wr_acc, sel_i[0]))
        mode_q <= dat_i[7:0];
      if (wr_to(idx, IDX_IEN, wr_acc, sel_i[0]))
        ien_q <= dat_i[1:0];
      if (wr_to(idx, IDX_MASK, wr_acc, sel_i[0]))
        mask_q <= dat_i[ST_W-1:0];
    end
  end

  // reload/compare value; software write wins over capture
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rc_q <= CNT_CLEAR;
    else
    begin
      // capture copies the count in auto-reload mode
      if (ar_mode && cap_ev)
        rc_q <= cnt_q;
      if (wr_to(idx, IDX_RC_LO, wr_acc, sel_i[0]))
        rc_q[7:0] <= dat_i[7:0];
      if (wr_to(idx, IDX_RC_HI, wr_acc, sel_i[0]))
        rc_q[15:8] <= dat_i[7:0];
    end
  end

  // the count; a software byte write overrides hardware
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_q <= CNT_CLEAR;
    else
    begin
      if (cap_clr)
        cnt_q <= CNT_CLEAR;
      // gated reload from the reload value
      else if (reload_now)
        cnt_q <= rc_q;
      // match clear in compare mode only
      else if (match_ev && mode_q[MODE_MCLR])
        cnt_q <= CNT_CLEAR;
      // otherwise a capture leaves counting alone
      else if (step)
        cnt_q <= cnt_q + 16'h0001;
      if (wr_to(idx, IDX_CNT_LO, wr_acc, sel_i[0]))
        cnt_q[7:0] <= dat_i[7:0];
      if (wr_to(idx, IDX_CNT_HI, wr_acc, sel_i[0]))
        cnt_q[15:8] <= dat_i[7:0];
    end
  end

  // sticky status, cleared by reading it; a new event wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stat_q <= '0;
    else
    begin
      if (rd_acc && idx == IDX_STAT)
        stat_q <= '0;
      if (ovf_ev)
        stat_q[ST_OVF] <= 1'b1;
      if (match_ev)
        stat_q[ST_MATCH] <= 1'b1;
      if (reload_now)
        stat_q[ST_RELOAD] <= 1'b1;
      if (ar_mode && cap_ev)
        stat_q[ST_CAPT] <= 1'b1;
    end
  end

  // timer request needs the flag and both enables
  assign timer_irq_o = ctrl_q[CTRL_FLAG] && ien_q[IEN_TIMER] &&
                       ien_q[IEN_GLOBAL];
  // level summary of unmasked sticky events
  assign irq_o = |(stat_q & mask_q);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // flag follows the wrap one edge later
  a_flag_on_ovf: assert property (ovf_ev |=> ctrl_q[CTRL_FLAG])
    else $error("flag missed an overflow");
  // a compare match raises the same flag
  a_flag_on_match: assert property (match_ev |=> ctrl_q[CTRL_FLAG])
    else $error("flag missed a compare match");
  // request is a pure level of the flag and both enables
  a_irq_request: assert property (
    ctrl_q[CTRL_FLAG] && ien_q == 2'h3 |-> timer_irq_o)
    else $error("timer interrupt not requested");
  // only a control write may lower the flag
  a_flag_sticky: assert property (
    ctrl_q[CTRL_FLAG] && !wr_to(idx, IDX_CTRL, wr_acc, sel_i[0])
    |=> ctrl_q[CTRL_FLAG])
    else $error("flag cleared by hardware");
  // halted and untouched, the count keeps its value
  a_halt_holds: assert property (
    !dv.run && !cnt_wr && !reload_now && !cap_clr
    |=> $stable(cnt_q))
    else $error("count moved while halted");
  // matches exist only in compare mode
  a_no_match_reload: assert property (ar_mode |-> !match_ev)
    else $error("match in auto-reload mode");
  // with the gate closed an overflow simply wraps
  a_gate_off_wrap: assert property (
    ovf_ev && !mode_q[MODE_GATE] && !cnt_wr && !cap_clr
    |=> cnt_q == CNT_CLEAR)
    else $error("ungated overflow did not wrap");
  // with the gate open the reload value lands in the count
  a_reload_copy: assert property (
    reload_now && !cap_clr && !cnt_wr |=> cnt_q == $past(rc_q))
    else $error("reload did not load the count");
  // divide by four leaves three quiet cycles between ticks
  a_div_four: assert property (
    dv.tick && dv.run && dv.code == 3'h1 && $stable(dv.code)
    |=> !dv.tick [*3])
    else $error("divide by four ticked early");
  // capture hands the count over to the reload register
  a_capture_copy: assert property (
    ar_mode && cap_ev && !wr_acc |=> rc_q == $past(cnt_q))
    else $error("capture did not copy count");
  // auto-clear empties the count after the hand-over
  a_capture_clear: assert property (
    cap_clr && !cnt_wr |=> cnt_q == CNT_CLEAR)
    else $error("capture clear failed");
  // without auto-clear a capture leaves a quiet count alone
  a_capture_keep: assert property (
    ar_mode && cap_ev && !mode_q[MODE_CAPCLR] && !reload_now && !step &&
    !cnt_wr |=> $stable(cnt_q))
    else $error("capture moved the count");
  // match auto-clear empties the count
  a_match_clear: assert property (
    match_ev && mode_q[MODE_MCLR] && !cnt_wr
    |=> cnt_q == CNT_CLEAR)
    else $error("match clear failed");
  // a plain tick adds exactly one
  a_count_step: assert property (
    step && !ovf_ev && !match_ev && !cap_ev && !cnt_wr
    |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("count did not step");
  // the bus answer is a single-cycle pulse
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  // main scenarios worth seeing at least once
  c_overflow: cover property (ovf_ev ##1 timer_irq_o);
  c_match_clear: cover property (match_ev && mode_q[MODE_MCLR]);
  c_capture_reload: cover property (cap_ev && reload_now);
  c_capture_clear: cover property (cap_clr && !cnt_wr);
  c_status_read: cover property (rd_acc && idx == IDX_STAT && irq_o);
endmodule : timer_reload_compare
`default_nettype wire

// ===== test/tb.sv
// Purpose: self-checking bench for the reload/compare timer
// Assumes: classic Wishbone master, capture strobes driven here
// Notes: long divider codes keep tick moments far from bus jitter
`timescale 1ns/1ps
`default_nettype none
module tb;
  import timer_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [9:0] adr_i = 10'h000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [2:0] capture_i = 3'h0;
  logic timer_irq_o;
  logic irq_o;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0; // hang guard
  logic [7:0] rd; // last byte read
  logic [15:0] v; // last 16-bit value read
  int ratio [8] = '{1, 4, 16, 32, 64, 128, 256, 512};
  logic [7:0] ridx [9] = '{8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD,
    8'hE0, 8'hE1, 8'hE2};
  timer_reload_compare uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .capture_i(capture_i),
    .timer_irq_o(timer_irq_o), .irq_o(irq_o));
  // free running clock, 4 ns period
  always #2 clk_i = ~clk_i;
  // verdict and end of run, reached from the hang guard or the end of the sequence
  task automatic end_of_test();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // single compare point
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic [7:0] idx, input logic w,
                    input logic [7:0] val, input logic s0);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= {3'b000, s0};
    dat_i <= {24'h0, val};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    // compares after a call must see what the ack edge wrote
    @(negedge clk_i);
  endtask : wb
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    wb(idx, 1'b1, val, 1'b1);
  endtask : wr
  task automatic rd_chk(input string what, input logic [7:0] idx,
                        input logic [7:0] exp);
    wb(idx, 1'b0, 8'h00, 1'b1);
    check(what, {8'h00, rd}, {8'h00, exp});
  endtask : rd_chk
  // low byte first; bytes are independent, so read halted only
  task automatic rd16(input logic [7:0] lo);
    wb(lo, 1'b0, 8'h00, 1'b1);
    v[7:0] = rd;
    wb(lo + 8'h01, 1'b0, 8'h00, 1'b1);
    v[15:8] = rd;
  endtask : rd16
  task automatic wr16(input logic [7:0] lo, input logic [15:0] val);
    wr(lo, val[7:0]);
    wr(lo + 8'h01, val[15:8]);
  endtask : wr16
  task automatic pulse(input logic [2:0] ch);
    @(posedge clk_i);
    capture_i <= ch;
    @(posedge clk_i);
    capture_i <= 3'h0;
  endtask : pulse
  // hang guard: worst case run is near 22k cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles > 60000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial
  begin
    int e;
    int t;
    int ok;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ridx[i]) rd_chk("reset", ridx[i], 8'h00);
    // reserved control bits read zero, unmapped place reads zero
    wr(IDX_CTRL, 8'h7A);
    rd_chk("ctrl reserved", IDX_CTRL, 8'h00);
    wr(8'hD0, 8'hA5);
    rd_chk("unmapped", 8'hD0, 8'h00);
    // byte-disabled write is dropped
    wb(IDX_RC_LO, 1'b1, 8'h66, 1'b0);
    rd_chk("sel off", IDX_RC_LO, 8'h00);
    wr16(IDX_RC_LO, 16'hA55A);
    rd16(IDX_RC_LO);
    check("rc rw", v, 16'hA55A);
    // every divider code: count over a fixed halted-to-halted span
    for (int c = 0; c < 8; c++)
    begin
      wr16(IDX_CNT_LO, 16'h0000);
      wr(IDX_MODE, {1'b0, c[2:0], 4'h0});
      wr(IDX_CTRL, 8'h04);
      repeat (2048) @(posedge clk_i);
      wr(IDX_CTRL, 8'h00);
      rd16(IDX_CNT_LO);
      e = 2051 / ratio[c];
      t = (c == 0) ? 3 : 1;
      ok = int'(int'(v) >= e - t && int'(v) <= e + t);
      check("divider", 16'(ok), 16'h1);
    end
    // overflow with reload gate on and off
    for (int g = 0; g < 2; g++)
    begin
      wr(IDX_CTRL, 8'h00);
      wr16(IDX_CNT_LO, 16'hFFFF);
      wr16(IDX_RC_LO, 16'h1234);
      wr(IDX_MODE, {g[0], 7'h70});
      wr(IDX_IEN, 8'h03);
      wr(IDX_MASK, 8'h01);
      wr(IDX_CTRL, 8'h04);
      repeat (700) @(posedge clk_i);
      rd_chk("flag on overflow", IDX_CTRL, 8'h84);
      wr(IDX_CTRL, 8'h80);
      rd16(IDX_CNT_LO);
      check("after overflow", v, g ? 16'h1234 : 16'h0000);
      check("timer irq", {15'h0, timer_irq_o}, 16'h1);
      check("irq", {15'h0, irq_o}, 16'h1);
      wr(IDX_MASK, 8'h00);
      check("irq masked", {15'h0, irq_o}, 16'h0);
      wr(IDX_MASK, 8'h01);
      check("irq unmasked", {15'h0, irq_o}, 16'h1);
      rd_chk("status", IDX_STAT, g ? 8'h05 : 8'h01);
      check("irq cleared", {15'h0, irq_o}, 16'h0);
      check("flag kept", {15'h0, timer_irq_o}, 16'h1);
      wr(IDX_IEN, 8'h01);
      check("global off", {15'h0, timer_irq_o}, 16'h0);
    end
    // compare mode with and without match auto-clear
    for (int m = 0; m < 2; m++)
    begin
      wr(IDX_CTRL, 8'h00);
      rd_chk("ctrl cleared", IDX_CTRL, 8'h00);
      wr(IDX_MODE, {5'b01110, m[0], 2'b00});
      wr16(IDX_RC_LO, 16'h0002);
      wr16(IDX_CNT_LO, 16'h0000);
      wr(IDX_CTRL, 8'h05);
      repeat (1700) @(posedge clk_i);
      rd_chk("flag on match", IDX_CTRL, 8'h85);
      wr(IDX_CTRL, 8'h01);
      rd16(IDX_CNT_LO);
      check("after match", v, m ? 16'h0000 : 16'h0003);
      rd_chk("match status", IDX_STAT, 8'h02);
    end
    // capture on each channel, stray channels ignored
    // channel 2 also opens the reload gate, so the old value comes back
    for (int ch = 0; ch < 3; ch++)
    begin
      wr(IDX_CTRL, 8'h00);
      wr16(IDX_RC_LO, 16'h5555);
      wr16(IDX_CNT_LO, 16'h0ABC);
      wr(IDX_MODE, {(ch == 2), 3'h7, ch[0], 1'b0, 2'(ch + 1)});
      wr(IDX_CTRL, 8'h04);
      pulse(~(3'h1 << ch));
      pulse(3'h1 << ch);
      wr(IDX_CTRL, 8'h00);
      rd16(IDX_RC_LO);
      check("captured", v, 16'h0ABC);
      rd16(IDX_CNT_LO);
      e = (ch == 2) ? 32'h5555 : 32'h0ABC;
      check("count kept", v, ch[0] ? 16'h0000 : 16'(e));
      rd_chk("capture status", IDX_STAT, (ch == 2) ? 8'h0C : 8'h08);
    end
    end_of_test();
  end
endmodule : tb
`default_nettype wire
